// file: irqef_top.sv
// Purpose: Second interrupt enable register and both request flag registers
// Assumes: Peripheral counters and pulses share pclk; pins are asynchronous
// Notes:   APB slave with one wait state; request outputs are registered
//
// Added by the designer: the register addresses and the APB interface to the registers.
`include "irqef_map.svh"

module irqef_top #(
    parameter logic FULL_VARIANT = 1'b1
) (
    // Clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    input  wire logic [3:0]         pstrb,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    // External pins and their configuration
    input  wire logic [4:0]         irq_pin,
    input  wire logic [4:0]         irq_pin_is_int,
    input  wire logic [4:0]         irq_edge_rising,
    // Enables for the first request register sources
    input  wire irqef_pkg::irqef_byte_t enable_first,
    // Timer counters and compare values
    input  wire irqef_pkg::irqef_byte_t timer_a_count,
    input  wire irqef_pkg::irqef_byte_t timer_b_count,
    input  wire irqef_pkg::irqef_byte_t timer_c_count,
    input  wire irqef_pkg::irqef_byte_t timer_fh_count,
    input  wire irqef_pkg::irqef_byte_t timer_fl_count,
    input  wire irqef_pkg::irqef_byte_t timer_fh_cmp,
    input  wire irqef_pkg::irqef_byte_t timer_fl_cmp,
    input  wire logic               timer_f_16bit_mode,
    // Other peripheral events
    input  wire logic               serial1_xfer_done,
    input  wire logic               direct_xfer_done,
    input  wire logic               adc_start_busy,
    // Requests to the processor core
    output irqef_pkg::irqef_byte_t  req_first,
    output irqef_pkg::irqef_byte_t  req_second
);
    import irqef_pkg::*;

    //------------------------------------------------------------
    // Helpers
    //------------------------------------------------------------
    // Counter stepped from one value to another
    function automatic logic stepped(input irqef_byte_t prv,
                                     input irqef_byte_t cur,
                                     input irqef_byte_t from_v,
                                     input irqef_byte_t to_v);
        stepped = (prv == from_v) && (cur == to_v);
    endfunction : stepped

    // Flag update: hardware set wins over a software clear
    function automatic irqef_byte_t flag_next(input irqef_byte_t cur,
                                              input irqef_byte_t set_v,
                                              input logic        wr,
                                              input irqef_byte_t wdat,
                                              input irqef_byte_t mask);
        irqef_byte_t clr;
        clr       = wr ? ~wdat : 8'h00;
        flag_next = ((cur & ~clr) | set_v) & mask;
    endfunction : flag_next

    //------------------------------------------------------------
    // State
    //------------------------------------------------------------
    irqef_bus_st_t bus_st_r;
    irqef_bus_st_t bus_st_nxt;
    irqef_byte_t   enable2_r;
    irqef_byte_t   flags1_r;
    irqef_byte_t   flags2_r;
    irqef_byte_t   flags1_nxt;
    irqef_byte_t   flags2_nxt;
    irqef_byte_t   ta_prev_r;
    irqef_byte_t   tb_prev_r;
    irqef_byte_t   tc_prev_r;
    logic          cnt_valid_r;
    logic          fh_match_prev_r;
    logic          fl_match_prev_r;
    logic          adc_busy_prev_r;
    logic [31:0]   prdata_r;
    logic          pready_r;
    logic          pslverr_r;
    irqef_byte_t   req_first_r;
    irqef_byte_t   req_second_r;

    //------------------------------------------------------------
    // Pin synchroniser
    //------------------------------------------------------------
    logic [4:0] pin_rise;
    logic [4:0] pin_fall;

    irqef_sync u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .pin_raw  (irq_pin),
        .pin_rise (pin_rise),
        .pin_fall (pin_fall)
    );

    //------------------------------------------------------------
    // Address decode
    //------------------------------------------------------------
    // Register selects and completing-write strobes
    logic        sel_en2;
    logic        sel_fl1;
    logic        sel_fl2;
    logic        mapped;
    logic        access;
    logic        done;
    logic        wr_lane0;
    logic        wr_en2;
    logic        wr_fl1;
    logic        wr_fl2;
    irqef_byte_t wbyte;
    irqef_byte_t rd_byte;

    assign sel_en2  = (paddr == `IRQEF_OFS_ENABLE2);
    assign sel_fl1  = (paddr == `IRQEF_OFS_FLAGS1);
    assign sel_fl2  = (paddr == `IRQEF_OFS_FLAGS2);
    assign mapped   = sel_en2 | sel_fl1 | sel_fl2;
    assign access   = psel & penable;
    assign done     = access & pready_r;
    assign wr_lane0 = done & pwrite & pstrb[0] & mapped;
    assign wr_en2   = wr_lane0 & sel_en2;
    assign wr_fl1   = wr_lane0 & sel_fl1;
    assign wr_fl2   = wr_lane0 & sel_fl2;
    assign wbyte    = pwdata[7:0];

    // Read mux; reserved bit 5 of the first flags reads as one
    assign rd_byte  = sel_en2 ? enable2_r :
                      sel_fl1 ? (flags1_r | `IRQEF_RSV1_READ) :  // [RULE13]
                      sel_fl2 ? flags2_r : 8'h00;

    //------------------------------------------------------------
    // Bus state machine
    //------------------------------------------------------------
    // Idle until an access phase, then answer for exactly one cycle
    always_comb begin
        bus_st_nxt = bus_st_r;
        unique case (bus_st_r)
            IRQEF_ST_IDLE: begin
                if (access) begin
                    bus_st_nxt = IRQEF_ST_ACK;
                end
            end
            IRQEF_ST_ACK: begin
                bus_st_nxt = IRQEF_ST_IDLE;
            end
        endcase
    end

    // Ready, error and read data are loaded one cycle into the access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus_st_r  <= IRQEF_ST_IDLE;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= `IRQEF_ZERO32;
        end else begin
            bus_st_r  <= bus_st_nxt;
            pready_r  <= (bus_st_r == IRQEF_ST_IDLE) & access;
            pslverr_r <= (bus_st_r == IRQEF_ST_IDLE) & access & ~mapped;
            if ((bus_st_r == IRQEF_ST_IDLE) && access && !pwrite) begin
                prdata_r <= {24'h00_0000, rd_byte};
            end
        end
    end

    //------------------------------------------------------------
    // Event detection
    //------------------------------------------------------------
    // Counter wraps and compare-match rising edges
    logic        ta_wrap;
    logic        tb_wrap;
    logic        tc_ovf;
    logic        tc_unf;
    logic        fh_match;
    logic        fl_match;
    logic        fh_event;
    logic        fl_event;
    logic        adc_event;
    logic [4:0]  ext_edge;
    irqef_byte_t set1;
    irqef_byte_t set2;

    assign ta_wrap  = cnt_valid_r & stepped(ta_prev_r, timer_a_count,
                                            `IRQEF_CNT_MAX, `IRQEF_CNT_ZERO); // [RULE11]
    assign tb_wrap  = cnt_valid_r & stepped(tb_prev_r, timer_b_count,
                                            `IRQEF_CNT_MAX, `IRQEF_CNT_ZERO); // [RULE20]
    assign tc_ovf   = cnt_valid_r & stepped(tc_prev_r, timer_c_count,
                                            `IRQEF_CNT_MAX, `IRQEF_CNT_ZERO); // [RULE19]
    assign tc_unf   = cnt_valid_r & stepped(tc_prev_r, timer_c_count,
                                            `IRQEF_CNT_ZERO, `IRQEF_CNT_MAX); // [RULE19]

    // In 16-bit mode FH watches the joined counter and FL is silent
    assign fh_match = timer_f_16bit_mode ?
                      ({timer_fh_count, timer_fl_count} == {timer_fh_cmp, timer_fl_cmp}) :
                      (timer_fh_count == timer_fh_cmp);                       // [RULE18]
    assign fl_match = ~timer_f_16bit_mode & (timer_fl_count == timer_fl_cmp);
    assign fh_event = fh_match & ~fh_match_prev_r;
    assign fl_event = fl_match & ~fl_match_prev_r;

    // Conversion end is the fall of the start-busy indication
    assign adc_event = adc_busy_prev_r & ~adc_start_busy;                    // [RULE17]

    // Selected edge on pins configured as interrupt inputs
    assign ext_edge = irq_pin_is_int &
                      ((irq_edge_rising & pin_rise) | (~irq_edge_rising & pin_fall));

    // Set vectors for the first request register
    always_comb begin
        set1                = 8'h00;
        set1[`IRQEF_B_TA]   = ta_wrap;                                       // [RULE11]
        set1[`IRQEF_B_S1]   = FULL_VARIANT & serial1_xfer_done;              // [RULE12]
        set1[4:0]           = ext_edge & `IRQEF_EXT_PIN_MASK;                // [RULE14]
        set1[`IRQEF_B_X2]   = FULL_VARIANT & ext_edge[`IRQEF_B_X2];          // [RULE15]
    end

    // Set vectors for the second request register
    always_comb begin
        set2                = 8'h00;
        set2[`IRQEF_B_DT]   = direct_xfer_done;
        set2[`IRQEF_B_AD]   = adc_event;
        set2[`IRQEF_B_FH]   = fh_event;
        set2[`IRQEF_B_FL]   = fl_event;
        set2[`IRQEF_B_TC]   = FULL_VARIANT & (tc_ovf | tc_unf);
        set2[`IRQEF_B_TB]   = tb_wrap;                                       // [RULE16]
    end

    //------------------------------------------------------------
    // Request flags
    //------------------------------------------------------------
    // Only a zero written clears; set beats clear in the same cycle
    assign flags1_nxt = flag_next(flags1_r, set1, wr_fl1, wbyte,
                                  `IRQEF_FLAGS1_MASK);                       // [RULE10]
    assign flags2_nxt = flag_next(flags2_r, set2, wr_fl2, wbyte,
                                  `IRQEF_FLAGS2_MASK);                       // [RULE10]

    // Flags hold until software clears them; no acceptance input exists
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags1_r <= `IRQEF_RST_FLAGS;
            flags2_r <= `IRQEF_RST_FLAGS;                                    // [RULE16]
        end else begin
            flags1_r <= flags1_nxt;                                          // [RULE9]
            flags2_r <= flags2_nxt;                                          // [RULE9]
        end
    end

    //------------------------------------------------------------
    // Second enable register
    //------------------------------------------------------------
    // Fully read/write; reserved bits 5 and 4 are stored but gate nothing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable2_r <= `IRQEF_RST_ENABLE2;                                 // [RULE1] [RULE8]
        end else if (wr_en2) begin
            enable2_r <= wbyte;
        end
    end

    //------------------------------------------------------------
    // Event history
    //------------------------------------------------------------
    // Previous counter values and condition levels for edge finding
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ta_prev_r       <= `IRQEF_CNT_ZERO;
            tb_prev_r       <= `IRQEF_CNT_ZERO;
            tc_prev_r       <= `IRQEF_CNT_ZERO;
            cnt_valid_r     <= 1'b0;
            fh_match_prev_r <= 1'b1;
            fl_match_prev_r <= 1'b1;
            adc_busy_prev_r <= 1'b0;
        end else begin
            ta_prev_r       <= timer_a_count;
            tb_prev_r       <= timer_b_count;
            tc_prev_r       <= timer_c_count;
            cnt_valid_r     <= 1'b1;
            fh_match_prev_r <= fh_match;
            fl_match_prev_r <= fl_match;
            adc_busy_prev_r <= adc_start_busy;
        end
    end

    //------------------------------------------------------------
    // Requests to the core
    //------------------------------------------------------------
    // Each request is its flag gated by the matching enable bit
    irqef_byte_t gate2;
    irqef_byte_t req_first_nxt;
    irqef_byte_t req_second_nxt;

    always_comb begin
        gate2              = 8'h00;
        gate2[`IRQEF_B_DT] = enable2_r[`IRQEF_B_DT];                         // [RULE1]
        gate2[`IRQEF_B_AD] = enable2_r[`IRQEF_B_AD];                         // [RULE2]
        gate2[`IRQEF_B_FH] = enable2_r[`IRQEF_B_FH];                         // [RULE4]
        gate2[`IRQEF_B_FL] = enable2_r[`IRQEF_B_FL];                         // [RULE5]
        gate2[`IRQEF_B_TC] = enable2_r[`IRQEF_B_TC];                         // [RULE6]
        gate2[`IRQEF_B_TB] = enable2_r[`IRQEF_B_TB];                         // [RULE8]
    end

    assign req_first_nxt  = flags1_r & enable_first & `IRQEF_FLAGS1_MASK;    // [RULE21]
    assign req_second_nxt = flags2_r & gate2;                                // [RULE21]

    // Registered request outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            req_first_r  <= 8'h00;
            req_second_r <= 8'h00;
        end else begin
            req_first_r  <= req_first_nxt;
            req_second_r <= req_second_nxt;
        end
    end

    //------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------
    assign prdata     = prdata_r;
    assign pready     = pready_r;
    assign pslverr    = pslverr_r;
    assign req_first  = req_first_r;
    assign req_second = req_second_r;

endmodule : irqef_top

// file: irqef_map.svh
// Purpose: Register offsets, bit positions, reset values and count limits
// Assumes: Included by its bare name from every design file that needs it
// Notes:   Definitions only, guarded against double inclusion
//
// Summary of operation
// RULE1 - Enable bit 7 of second enable register gates direct transfer; resets 0.
// RULE2 - Enable bit 6 gates A/D converter requests; 0 disables, resets 0.
// RULE3 - Software writes 0 to reserved bits 5 and 4 of second enable register.
// RULE4 - Enable bit 3 gates timer FH compare-match and overflow requests.
// RULE5 - Enable bit 2 gates timer FL compare-match and overflow requests.
// RULE6 - Enable bit 1 gates timer C overflow and underflow requests.
// RULE7 - On the reduced variant software keeps the timer C enable at 0.
// RULE8 - Enable bit 0 gates timer B requests; resets to 0.
// RULE9 - Flags are never cleared on interrupt acceptance; only software clears.
// RULE10 - Writing 0 clears a set flag; writing 1 changes nothing.
// RULE11 - Timer A flag, first register bit 7, sets on counter wrap to zero.
// RULE12 - Serial channel one flag, bit 6, sets on transfer completion; this design sets it on the full variant only.
// RULE13 - Bit 5 of first request register reads 1; writes ignored.
// RULE14 - External flags 4,3,1,0 set on selected edge of interrupt-configured pin.
// RULE15 - External flag 2 likewise, present on the full variant only.
// RULE16 - Second request register: DT7, AD6, FH3, FL2, C1, B0, all reset 0.
// RULE17 - A/D flag sets when conversion finishes and start-busy is reset.
// RULE18 - FH flag on 8-bit FH match, or 16-bit combined match in 16-bit mode.
// RULE19 - Timer C flag on overflow all-ones to zero or underflow zero to ones.
// RULE20 - Timer B flag sets on overflow from maximum count to zero.
// RULE21 - A request is presented while a flag and its enable are both 1.
`ifndef IRQEF_MAP_SVH
`define IRQEF_MAP_SVH

//------------------------------------------------------------
// Register byte offsets
//------------------------------------------------------------
`define IRQEF_OFS_ENABLE2   12'h000
`define IRQEF_OFS_FLAGS1    12'h004
`define IRQEF_OFS_FLAGS2    12'h008

//------------------------------------------------------------
// Second enable register and second request register bits
//------------------------------------------------------------
`define IRQEF_B_DT          7
`define IRQEF_B_AD          6
`define IRQEF_B_FH          3
`define IRQEF_B_FL          2
`define IRQEF_B_TC          1
`define IRQEF_B_TB          0

//------------------------------------------------------------
// First request register bits
//------------------------------------------------------------
`define IRQEF_B_TA          7
`define IRQEF_B_S1          6
`define IRQEF_B_X2          2

//------------------------------------------------------------
// Reset values, masks and counter limits
//------------------------------------------------------------
`define IRQEF_RST_ENABLE2   8'h00
`define IRQEF_RST_FLAGS     8'h00
`define IRQEF_FLAGS1_MASK   8'hDF
`define IRQEF_FLAGS2_MASK   8'hCF
`define IRQEF_RSV1_READ     8'h20
`define IRQEF_EXT_PIN_MASK  5'h1B
`define IRQEF_CNT_MAX       8'hFF
`define IRQEF_CNT_ZERO      8'h00
`define IRQEF_ZERO32        32'h0000_0000

`endif

// file: irqef_pkg.sv
// Purpose: Types shared by the interrupt flag block
// Assumes: Nothing beyond the map header
// Notes:   Holds the bus state encoding and the byte type
package irqef_pkg;

    // One-hot bus slave states
    typedef enum logic [1:0] {
        IRQEF_ST_IDLE = 2'b01,
        IRQEF_ST_ACK  = 2'b10
    } irqef_bus_st_t;

    typedef logic [7:0] irqef_byte_t;

endpackage : irqef_pkg

// file: irqef_sync.sv
// Purpose: Three-stage pin synchroniser with agreement filter and edge pulses
// Assumes: Pins are asynchronous to pclk
// Notes:   The level only moves when stages two and three agree
`include "irqef_map.svh"

module irqef_sync (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Raw pins and filtered edges
    input  wire logic [4:0] pin_raw,
    output logic      [4:0] pin_rise,
    output logic      [4:0] pin_fall
);
    import irqef_pkg::*;

    logic [4:0] stage1_r;
    logic [4:0] stage2_r;
    logic [4:0] stage3_r;
    logic [4:0] level_r;
    logic [4:0] level_nxt;
    logic [4:0] agree;
    logic       primed_r;

    //------------------------------------------------------------
    // Filter
    //------------------------------------------------------------
    // Stages two and three must agree before the level follows
    assign agree     = ~(stage2_r ^ stage3_r);
    assign level_nxt = (agree & stage3_r) | (~agree & level_r);

    // Edges are suppressed until the level has been loaded once
    assign pin_rise  = {5{primed_r}} & level_nxt & ~level_r;
    assign pin_fall  = {5{primed_r}} & ~level_nxt & level_r;

    // Synchroniser chain; stage one feeds stage two only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1_r <= 5'h00;
            stage2_r <= 5'h00;
            stage3_r <= 5'h00;
        end else begin
            stage1_r <= pin_raw;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
        end
    end

    // Filtered level and first-load marker
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_r  <= 5'h00;
            primed_r <= 1'b0;
        end else begin
            level_r  <= primed_r ? level_nxt : stage3_r;
            primed_r <= primed_r | (&agree);
        end
    end

endmodule : irqef_sync

// file: irqef_cnt_model.sv
// Purpose: Timer counter model feeding the block's count inputs
// Assumes: Same clock as the block
// Notes:   Load wins over counting; the count wraps both ways
module irqef_cnt_model (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Count control
    input  wire logic       ld,
    input  wire logic [7:0] ldv,
    input  wire logic       up,
    input  wire logic       dn,
    // Counter value
    output logic      [7:0] cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    // Load, or step up or down by one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 8'h00;
        end else if (ld) begin
            cnt <= ldv;
        end else begin
            cnt <= cnt + {7'h00, up} - {7'h00, dn};
        end
    end
endmodule : irqef_cnt_model

// file: irqef_top_assertions.sv
// Purpose: Port-level checks of the interrupt flag block
// Assumes: Timer counts stay still around flag clears
// Notes:   One clock domain
`include "irqef_map.svh"
module irqef_top_assertions (
    // Clock and reset
    input wire logic                   pclk,
    input wire logic                   presetn,
    // APB
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [11:0]            paddr,
    input wire logic [31:0]            pwdata,
    input wire logic [3:0]             pstrb,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    // Sources and requests
    input wire irqef_pkg::irqef_byte_t enable_first,
    input wire irqef_pkg::irqef_byte_t timer_a_count,
    input wire irqef_pkg::irqef_byte_t req_first,
    input wire irqef_pkg::irqef_byte_t req_second
);
    timeunit 1ns;
    timeprecision 1ps;
    // Decode of the completing transfer
    wire f1 = paddr == `IRQEF_OFS_FLAGS1;
    wire f2 = paddr == `IRQEF_OFS_FLAGS2;
    wire mapped = f1 || f2 || paddr == `IRQEF_OFS_ENABLE2;
    wire wr_ok = pready && pwrite && pstrb[0] && !pslverr;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_access;
        psel && penable && !pready;
    endsequence
    sequence s_ta_wrap;
        timer_a_count == `IRQEF_CNT_ZERO && $past(timer_a_count) == `IRQEF_CNT_MAX;
    endsequence
    a_ready_one_wait: assert property (s_access |=> pready)
        else $error("pready late");
    a_ready_one_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_decode: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr decode wrong");
    a_read_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("read upper bits not zero");
    a_rsv_reads_one: assert property (pready && !pwrite && f1 |-> prdata[5])
        else $error("reserved flag bit not one");
    a_rsv_second_zero: assert property (pready && !pwrite && f2 |-> !prdata[5:4])
        else $error("reserved second flag bits not zero");
    a_ta_wrap_req: assert property (s_ta_wrap ##0 enable_first[7] |-> ##2 req_first[7])
        else $error("timer A wrap gave no request");
    a_req_rsv_zero: assert property (req_first[5] == 1'b0 && req_second[5:4] == 2'b00)
        else $error("request on a reserved position");
    a_clear_first: assert property (wr_ok && f1 |-> ##2
        (req_first & ~$past(pwdata[7:0], 2)) == 8'h00) else $error("first request not cleared");
    a_clear_second: assert property (wr_ok && f2 |-> ##2
        (req_second & ~$past(pwdata[7:0], 2)) == 8'h00) else $error("second request not cleared");
endmodule : irqef_top_assertions

// file: irqef_top_tb.sv
// Purpose: Self-checking bench for the interrupt flag block
// Assumes: Full variant; both timer F modes and both pin edge senses
// Notes:   Counter models drive the timer counts
`include "irqef_map.svh"
module irqef_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import irqef_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    logic        pready, pslverr, e, s1 = 0, dt = 0, adb = 0, m16 = 0;
    logic [4:0]  pin = '0, ld = '0, up = '0, dn = '0, edg = 5'h1F;
    logic [39:0] ldv = 40'h06_04_00_FF_FF, cnt;
    irqef_byte_t en1 = '0, rq1, rq2;
    int          n_fail = 0, n_tests = 0;
    // Clock
    always #2 pclk = ~pclk;
    // Design and counter models, index A B C FH FL
    irqef_top #(.FULL_VARIANT(1'b1)) i_irqef_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_pin(pin), .irq_pin_is_int(5'h1F), .irq_edge_rising(edg),
        .enable_first(en1), .timer_a_count(cnt[7:0]), .timer_b_count(cnt[15:8]),
        .timer_c_count(cnt[23:16]), .timer_fh_count(cnt[31:24]), .timer_fl_count(cnt[39:32]),
        .timer_fh_cmp(8'h05), .timer_fl_cmp(8'h07), .timer_f_16bit_mode(m16),
        .serial1_xfer_done(s1), .direct_xfer_done(dt), .adc_start_busy(adb),
        .req_first(rq1), .req_second(rq2));
    irqef_cnt_model i_irqef_cnt_model [4:0] (.pclk(pclk), .presetn(presetn), .ld(ld),
        .ldv(ldv), .up(up), .dn(dn), .cnt(cnt));
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : summarize
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer; read data and error land in q and e
    task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge pclk);
        if (i == 20) begin
            n_fail++;
            summarize();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(a, 1'b0, 32'h0000_0000);
        chk(q, x);
    endtask : rd
    // Load counts then step once: wraps A and B, C underflows, FH and FL match
    task automatic fire(input logic [4:0] m);
        @(posedge pclk);
        ld <= m;
        @(posedge pclk);
        ld <= 5'h00;
        up <= m & 5'h1B;
        dn <= m & 5'h04;
        @(posedge pclk);
        up <= 5'h00;
        dn <= 5'h00;
    endtask : fire
    task automatic t_reset();
        rd(`IRQEF_OFS_ENABLE2, 32'h00);
        rd(`IRQEF_OFS_FLAGS1, 32'h20);
        rd(`IRQEF_OFS_FLAGS2, 32'h00);
        rd(12'h00C, 32'h00);
        chk({31'h0, e}, 32'h1);
    endtask : t_reset
    task automatic t_second();
        apb(`IRQEF_OFS_ENABLE2, 1'b1, 32'hCF);
        rd(`IRQEF_OFS_ENABLE2, 32'hCF);
        dt <= 1'b1;
        adb <= 1'b1;
        @(posedge pclk);
        dt <= 1'b0;
        adb <= 1'b0;
        fire(5'h1E);
        repeat (3) @(posedge pclk);
        chk(rq2, 32'hCF);
        rd(`IRQEF_OFS_FLAGS2, 32'hCF);
        apb(`IRQEF_OFS_ENABLE2, 1'b1, 32'h01);
        repeat (2) @(posedge pclk);
        chk(rq2, 32'h01);
        apb(`IRQEF_OFS_FLAGS2, 1'b1, 32'h02);
        apb(`IRQEF_OFS_FLAGS2, 1'b1, 32'hFF);
        repeat (40) @(posedge pclk);
        rd(`IRQEF_OFS_FLAGS2, 32'h02);
        chk(rq2, 32'h00);
        m16 <= 1'b1;
        fire(5'h18);
        rd(`IRQEF_OFS_FLAGS2, 32'h0A);
    endtask : t_second
    task automatic t_first();
        en1 <= 8'hFF;
        fire(5'h01);
        s1 <= 1'b1;
        pin <= 5'h1F;
        @(posedge pclk);
        s1 <= 1'b0;
        repeat (12) @(posedge pclk);
        rd(`IRQEF_OFS_FLAGS1, 32'hFF);
        chk(rq1, 32'hDF);
        apb(`IRQEF_OFS_FLAGS1, 1'b1, 32'h00);
        rd(`IRQEF_OFS_FLAGS1, 32'h20);
        edg <= 5'h00;
        pin <= 5'h00;
        apb(12'h00C, 1'b1, 32'hFF);
        chk({31'h0, e}, 32'h1);
        rd(`IRQEF_OFS_ENABLE2, 32'h01);
        rd(`IRQEF_OFS_FLAGS1, 32'h3F);
    endtask : t_first
    // Main sequence
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_second();
        t_first();
        summarize();
    end
endmodule : irqef_top_tb
bind irqef_top irqef_top_assertions i_irqef_top_assertions (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .enable_first(enable_first), .timer_a_count(timer_a_count), .req_first(req_first),
    .req_second(req_second));
